/* File: cksc_pkg.sv */
package cksc_pkg;

    // ****************************************
    // serial port framing
    // ****************************************
    localparam logic [7:0] CKSC_ADDR_WR       = 8'hd2; // address byte with write bit
    localparam logic [3:0] CKSC_BITS_PER_BYTE = 4'h8;  // whole bytes only
    localparam logic [2:0] CKSC_IDX_FIRST_REG = 3'h3;  // byte slot of register zero
    localparam logic [2:0] CKSC_IDX_LAST_REG  = 3'h5;  // byte slot of register two
    localparam logic [2:0] CKSC_IDX_MAX       = 3'h7;  // slot counter saturates here
    localparam logic [1:0] CKSC_STRAP_WAIT    = 2'h3;  // cycles before straps latch

    // ****************************************
    // register map and power-up values
    // ****************************************
    localparam int         CKSC_NUM_REGS = 3;
    localparam logic [1:0] CKSC_REG_FREQ = 2'h0;       // frequency_and_mode_select
    localparam logic [1:0] CKSC_REG_HOST = 2'h1;       // host_and_fixed_clock_enable
    localparam logic [1:0] CKSC_REG_BUS  = 2'h2;       // bus_clock_enable
    localparam logic [7:0] CKSC_RST [CKSC_NUM_REGS] = '{8'hf0, 8'hef, 8'h7f};

    // ****************************************
    // field positions
    // ****************************************
    localparam int CKSC_SW_SEL_LSB  = 4;  // table choice and three select bits
    localparam int CKSC_SRC_BIT     = 3;  // 1 = software selection
    localparam int CKSC_MODE_LSB    = 0;  // two output mode bits
    localparam int CKSC_USB_EN_BIT  = 7;  // 48 MHz enable
    localparam int CKSC_SIO_EN_BIT  = 6;  // 24 MHz enable
    localparam int CKSC_NORMAL_BIT  = 5;  // 0 = test mode
    localparam int CKSC_FR_EN_BIT   = 6;  // free-running bus clock enable

    // output modes
    localparam logic [1:0] CKSC_MODE_NORMAL = 2'h0;
    localparam logic [1:0] CKSC_MODE_SS15   = 2'h1; // centre spread 1.5 percent
    localparam logic [1:0] CKSC_MODE_SS06   = 2'h2; // centre spread 0.6 percent
    localparam logic [1:0] CKSC_MODE_TRI    = 2'h3; // all clock outputs floating except the usb48 and sio24 fixed clocks

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic       table_choice;  // freq_table_choice
        logic [2:0] fs;            // freq_select_bit_two..zero
    } cksc_freq_sel_t;

    typedef struct packed {
        logic       pin_mode;      // latched pin-function select
        logic [3:0] host_en;
        logic [6:0] bus_en;        // bit 6 is the free-running clock
    } cksc_cfg_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RX   = 4'b0010,
        ST_ACK  = 4'b0100,
        ST_SKIP = 4'b1000
    } cksc_ser_st_t;

    // ****************************************
    // frequency tables in kHz, index {table, fs}
    // ****************************************
    localparam logic [16:0] CKSC_HOST_KHZ [16] = '{
        17'h0f3c0, 17'h130b0, 17'h14f28, 17'h10f7c, 17'h14564, 17'h124f8, 17'h13880, 17'h0c350,
        17'h0f168, 17'h124f8, 17'h14564, 17'h10b94, 17'h0d6d8, 17'h124f8, 17'h0ea60, 17'h104f0};
    localparam logic [16:0] CKSC_BUS_KHZ [16] = '{
        17'h079e0, 17'h09858, 17'h0a730, 17'h087b4, 17'h0a2e4, 17'h07d00, 17'h09c40, 17'h061a8,
        17'h078b4, 17'h07530, 17'h08214, 17'h085ca, 17'h06b6c, 17'h0927c, 17'h07530, 17'h08278};
    localparam logic [16:0] CKSC_REF_KHZ = 17'h037ee; // crystal rate, every selection

endpackage : cksc_pkg

/* File: cksc_top.sv */
module cksc_top
    import cksc_pkg::*;
(
    // core clock and power-up reset
    input  wire logic             core_clk_i,
    input  wire logic             arst_n_i,
    // clock sources from the synthesiser
    input  wire logic             bus_clk_src_i,
    input  wire logic             host_clk_src_i,
    input  wire logic             ref_clk_src_i,
    input  wire logic             usb_clk_src_i,
    input  wire logic             sio_clk_src_i,
    // two-wire serial port
    input  wire logic             serial_clock_line_i,
    input  wire logic             serial_data_line_i,
    output logic                  serial_data_line_o,
    output logic                  serial_data_line_oe_o,
    // host and memory clocks
    output logic [3:0]            host_clock_out_o,
    output logic                  host_clock_out_oe_o,
    output logic [11:0]           mem_clk_o,
    output logic                  mem_clk_oe_o,
    // bus clocks, shared pins 0, 1 and 5
    input  wire logic [5:0]       bus_clock_out_i,
    output logic [5:0]            bus_clock_out_o,
    output logic [5:0]            bus_clock_out_oe_o,
    input  wire logic             free_running_bus_clock_i,
    output logic                  free_running_bus_clock_o,
    output logic                  free_running_bus_clock_oe_o,
    // crystal-rate clocks, ref 1 shares the host stop
    input  wire logic             ref1_i,
    output logic [1:0]            ref_clk_o,
    output logic [1:0]            ref_clk_oe_o,
    output logic                  interrupt_controller_clock_o,
    output logic                  interrupt_controller_clock_oe_o,
    // fixed clocks, both shared with straps
    input  wire logic             usb48_i,
    output logic                  usb48_o,
    output logic                  usb48_oe_o,
    input  wire logic             sio24_i,
    output logic                  sio24_o,
    output logic                  sio24_oe_o,
    // controls to the synthesiser
    output cksc_freq_sel_t        freq_sel_o,
    output logic [1:0]            spread_mode_o,
    output logic [16:0]           host_freq_khz_o,
    output logic [16:0]           bus_freq_khz_o,
    output logic [16:0]           ref_freq_khz_o,
    output logic                  test_mode_o
);

    // ****************************************
    // power-up straps
    // ****************************************
    logic [4:0] strap_m;     // first sync stage
    logic [4:0] strap_s;     // second sync stage
    logic [4:0] strap_q;     // {table, fs2, fs1, fs0, pin_mode}
    logic [1:0] strap_wait;  // settle count after release
    logic       strap_done;  // pins now drive clocks
    logic [4:0] strap_raw;   // pad levels

    assign strap_raw = {bus_clock_out_i[1], bus_clock_out_i[0],
                        free_running_bus_clock_i, usb48_i, sio24_i};

    // straps caught after release, never by the reset itself
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_m    <= 5'h00;
            strap_s    <= 5'h00;
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
            strap_q    <= 5'h1f; // pull-up levels
        end else begin
            strap_m <= strap_raw;
            strap_s <= strap_m;
            if (strap_wait != CKSC_STRAP_WAIT) begin
                strap_wait <= 2'(strap_wait + 2'h1);
            end else if (!strap_done) begin
                strap_q    <= strap_s;
                strap_done <= 1'b1;
            end
        end
    end

    // ****************************************
    // serial line sampling
    // ****************************************
    logic scl_m, scl_s, scl_q; // meta, synced, delayed
    logic sda_m, sda_s, sda_q;

    // two flops per pin, the third only for edges
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_q} <= {serial_clock_line_i, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {serial_data_line_i, sda_m, sda_s};
        end
    end

    wire scl_rise  = scl_s & ~scl_q;
    wire scl_fall  = ~scl_s & scl_q;
    wire ser_start = scl_s & scl_q & sda_q & ~sda_s;
    wire ser_stop  = scl_s & scl_q & ~sda_q & sda_s;

    // ****************************************
    // serial slave state machine
    // ****************************************
    cksc_ser_st_t state, next_state;
    logic [7:0]   shift, next_shift;       // byte being received
    logic [3:0]   bit_cnt, next_bit_cnt;   // bits of current byte
    logic [2:0]   byte_idx, next_byte_idx; // slot in transfer

    // only the address byte can be refused
    wire addr_bad  = (byte_idx == 3'h0) && (shift != CKSC_ADDR_WR);
    wire byte_full = (bit_cnt == CKSC_BITS_PER_BYTE);
    wire ack_end   = (state == ST_ACK) && scl_fall;
    // slots 1 and 2 are acked with contents dropped
    wire wr_en     = ack_end && (byte_idx >= CKSC_IDX_FIRST_REG)
                     && (byte_idx <= CKSC_IDX_LAST_REG);
    wire [1:0] wr_sel = 2'(byte_idx - CKSC_IDX_FIRST_REG);

    always_comb begin
        next_state    = state;
        next_shift    = shift;
        next_bit_cnt  = bit_cnt;
        next_byte_idx = byte_idx;
        // a start restarts framing from any state
        if (ser_start) begin
            next_state    = ST_RX;
            next_bit_cnt  = 4'h0;
            next_byte_idx = 3'h0;
        end else if (ser_stop) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_RX: begin
                    // data taken while the clock is high
                    if (scl_rise && !byte_full) begin
                        next_shift   = {shift[6:0], sda_s};
                        next_bit_cnt = 4'(bit_cnt + 4'h1);
                    end else if (scl_fall && byte_full) begin
                        next_bit_cnt = 4'h0;
                        next_state   = addr_bad ? ST_SKIP : ST_ACK;
                    end
                end
                ST_ACK: begin
                    // slots advance in strict order
                    if (scl_fall) begin
                        next_state = ST_RX;
                        if (byte_idx != CKSC_IDX_MAX) begin
                            next_byte_idx = 3'(byte_idx + 3'h1);
                        end
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    next_state = state; // wait for start
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state    <= ST_IDLE;
            shift    <= 8'h00;
            bit_cnt  <= 4'h0;
            byte_idx <= 3'h0;
        end else begin
            state    <= next_state;
            shift    <= next_shift;
            bit_cnt  <= next_bit_cnt;
            byte_idx <= next_byte_idx;
        end
    end

    // never drives high, so no read path exists
    assign serial_data_line_o    = 1'b0;
    assign serial_data_line_oe_o = (state == ST_ACK);

    // ****************************************
    // control registers
    // ****************************************
    logic [7:0] ctrl_q [CKSC_NUM_REGS];

    // power-up reset is the only path to defaults
    for (genvar g = 0; g < CKSC_NUM_REGS; g++) begin : g_reg
        always_ff @(posedge core_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                ctrl_q[g] <= CKSC_RST[g];
            end else if (wr_en && (wr_sel == 2'(g))) begin
                ctrl_q[g] <= shift;
            end
        end
    end

    wire [7:0] reg_freq = ctrl_q[CKSC_REG_FREQ];
    wire [7:0] reg_host = ctrl_q[CKSC_REG_HOST];
    wire [7:0] reg_bus  = ctrl_q[CKSC_REG_BUS];

    wire [1:0] out_mode = reg_freq[CKSC_MODE_LSB +: 2];
    wire       tristate = (out_mode == CKSC_MODE_TRI);
    wire       src_sw   = reg_freq[CKSC_SRC_BIT];
    wire       pin_mode = strap_q[0];
    wire cksc_freq_sel_t sw_sel = reg_freq[CKSC_SW_SEL_LSB +: 4];
    wire cksc_freq_sel_t hw_sel = strap_q[4:1];
    wire cksc_freq_sel_t next_sel = src_sw ? sw_sel : hw_sel;

    // ****************************************
    // synthesiser controls
    // ****************************************
    // one registered step; the loop ramps to it
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            freq_sel_o      <= '0;
            spread_mode_o   <= CKSC_MODE_NORMAL;
            host_freq_khz_o <= 17'h00000;
            bus_freq_khz_o  <= 17'h00000;
            ref_freq_khz_o  <= 17'h00000;
            test_mode_o     <= 1'b0;
        end else begin
            freq_sel_o      <= next_sel;
            spread_mode_o   <= out_mode;
            host_freq_khz_o <= CKSC_HOST_KHZ[next_sel];
            bus_freq_khz_o  <= CKSC_BUS_KHZ[next_sel];
            ref_freq_khz_o  <= CKSC_REF_KHZ;
            test_mode_o     <= ~reg_host[CKSC_NORMAL_BIT];
        end
    end

    // config word launched from a flop for crossing
    cksc_cfg_t cfg_q;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= {pin_mode, reg_host[3:0], reg_bus[6:0]};
        end
    end

    // ****************************************
    // bus clock domain: stop gating
    // ****************************************
    cksc_cfg_t  cfg_m, cfg_s;   // quasi-static, level sync
    logic [1:0] stop_m, stop_s; // {host stop, bus stop}, low active
    logic [3:0] host_run_q;     // taken on bus source rise
    logic [6:0] bus_run_q;
    logic [6:0] bus_gate;       // updated on own falling edge
    logic [3:0] host_gate;

    always_ff @(posedge bus_clk_src_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_m  <= '0;
            cfg_s  <= '0;
            stop_m <= 2'h3;
            stop_s <= 2'h3;
        end else begin
            cfg_m  <= cfg_q;
            cfg_s  <= cfg_m;
            stop_m <= {ref1_i, bus_clock_out_i[5]};
            stop_s <= stop_m;
        end
    end

    // stops count only when the pins serve as inputs
    wire host_go = cfg_s.pin_mode | stop_s[1];
    wire bus_go  = cfg_s.pin_mode | stop_s[0];
    // free-running clock ignores the bus stop
    wire [3:0] host_run = cfg_s.host_en & {4{host_go}};
    wire [6:0] bus_run  = cfg_s.bus_en & {1'b1, {6{bus_go}}};

    always_ff @(posedge bus_clk_src_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            host_run_q <= 4'h0;
            bus_run_q  <= 7'h00;
        end else begin
            host_run_q <= host_run;
            bus_run_q  <= bus_run;
        end
    end

    // gate moves only while its clock is low
    always_ff @(negedge bus_clk_src_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_gate <= 7'h00;
        end else begin
            bus_gate <= bus_run_q;
        end
    end

    // host and bus clocks share one loop, so one flop is
    // safe here; unrelated sources would need a sync
    always_ff @(negedge host_clk_src_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            host_gate <= 4'h0;
        end else begin
            host_gate <= host_run_q;
        end
    end

    // ****************************************
    // output pins
    // ****************************************
    assign host_clock_out_o         = {4{host_clk_src_i}} & host_gate;
    assign bus_clock_out_o          = {6{bus_clk_src_i}} & bus_gate[5:0];
    assign free_running_bus_clock_o = bus_clk_src_i & bus_gate[CKSC_FR_EN_BIT];
    assign mem_clk_o                = {12{host_clk_src_i}}; // follows host rate
    assign ref_clk_o                = {2{ref_clk_src_i}};
    assign interrupt_controller_clock_o = ref_clk_src_i;
    // fixed clocks gated directly: a write mid-high can
    // clip one pulse, accepted for these slow outputs
    assign usb48_o = usb_clk_src_i & reg_host[CKSC_USB_EN_BIT];
    assign sio24_o = sio_clk_src_i & reg_host[CKSC_SIO_EN_BIT];

    // shared pins stay inputs until straps are held
    assign host_clock_out_oe_o          = ~tristate;
    assign mem_clk_oe_o                 = ~tristate;
    assign interrupt_controller_clock_oe_o = ~tristate;
    assign ref_clk_oe_o                 = {~tristate & pin_mode & strap_done, ~tristate};
    assign bus_clock_out_oe_o           = {6{~tristate & strap_done}}
                                          & {pin_mode, 5'h1f};
    assign free_running_bus_clock_oe_o  = ~tristate & strap_done;
    assign usb48_oe_o                   = strap_done;
    assign sio24_oe_o                   = strap_done;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_byte_acked;
        (state == ST_ACK) && scl_fall;
    endsequence

    sequence s_addr_refused;
        (state == ST_RX) && scl_fall && byte_full && addr_bad && !ser_start && !ser_stop;
    endsequence

    tri_state_out_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        tristate |-> !host_clock_out_oe_o && !mem_clk_oe_o && (ref_clk_oe_o == 2'h0)
                     && !interrupt_controller_clock_oe_o && (bus_clock_out_oe_o == 6'h00)
                     && !free_running_bus_clock_oe_o)
        else $error("outputs driven in floating mode");

    sw_freq_sel_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        src_sw |=> (freq_sel_o == $past(sw_sel)))
        else $error("software selection not applied");

    hw_freq_sel_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        arst_n_i && !src_sw |=> (freq_sel_o == $past(hw_sel))
                    && (host_freq_khz_o == CKSC_HOST_KHZ[$past(hw_sel)]))
        else $error("pin selection not applied");

    ack_pull_low_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ((state == ST_RX) && scl_fall && byte_full && !addr_bad && !ser_start && !ser_stop)
        |=> serial_data_line_oe_o && !serial_data_line_o)
        else $error("good byte not acknowledged");

    write_only_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        serial_data_line_oe_o |-> (state == ST_ACK) && (bit_cnt == 4'h0))
        else $error("data line driven outside acknowledge");

    reg_zero_load_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (s_byte_acked ##0 (byte_idx == CKSC_IDX_FIRST_REG) && !ser_start && !ser_stop)
        |=> (ctrl_q[CKSC_REG_FREQ] == $past(shift)) && (byte_idx == 3'h4))
        else $error("first data byte not loaded");

    addr_refuse_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        s_addr_refused |=> (state == ST_SKIP) && !serial_data_line_oe_o)
        else $error("wrong address acknowledged");

    start_frame_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ser_start |=> (state == ST_RX) && (bit_cnt == 4'h0) && (byte_idx == 3'h0))
        else $error("start did not reset framing");

    stop_frame_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ser_stop && !ser_start |=> (state == ST_IDLE) && !serial_data_line_oe_o)
        else $error("stop did not end transfer");

    host_stop_a: assert property (@(posedge bus_clk_src_i) disable iff (!arst_n_i)
        (!cfg_s.pin_mode && !stop_s[1]) |=> (host_run_q == 4'h0))
        else $error("host clocks kept running under stop");

endmodule : cksc_top

/* File: cksc_i2c_master.sv */
module cksc_i2c_master (
    // core clock paces the bit timing
    input  wire logic clk_i,
    input  wire logic sda_i,
    // clock driven directly; data open-drain, pull high = drive low
    output logic      scl_o,
    output logic      sda_pull_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // ****************************************
    // one write transfer, returns acks seen
    // ****************************************
    task automatic xfer(input logic [7:0] q [$], output int acks);
        acks = 0;
        sda_pull_o <= 1'b1; // start while clock high
        repeat (6) @(posedge clk_i);
        foreach (q[i]) begin
            for (int b = 7; b >= -1; b--) begin // msb first, then ack slot
                scl_o <= 1'b0;
                repeat (3) @(posedge clk_i);
                sda_pull_o <= (b >= 0) ? ~q[i][b] : 1'b0; // data moves only while low
                repeat (3) @(posedge clk_i);
                scl_o <= 1'b1;
                repeat (6) @(posedge clk_i);
                if (b < 0 && sda_i === 1'b0) acks++;
            end
        end
        scl_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        sda_pull_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        sda_pull_o <= 1'b0; // stop: data rises with clock high
        repeat (6) @(posedge clk_i);
    endtask : xfer
endmodule : cksc_i2c_master

/* File: cksc_top_tb.sv */
module cksc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cksc_pkg::*;
    // ****************************************
    // clocks, pads, bookkeeping
    // ****************************************
    logic           core_clk_i = 1'b0;
    logic           arst_n_i = 1'b0;
    logic           bus_clk = 1'b0;       // link clock, 15 ns
    logic           xtal = 1'b0;          // fixed-rate sources
    logic           ref1_i = 1'b1;        // host stop, low active
    logic           stop_bus_n = 1'b1;    // bus stop, low active
    logic [4:0]     strap = 5'h02;        // pin function, table, fs2..fs0
    int             bad_count = 0;
    int             comparisons = 0;
    int             acks;
    logic [6:0]     seen;                 // outputs seen high in a window
    logic           scl, m_pull, sda_w, sda_oe, fr_o, fr_oe, usb_o, usb_oe, sio_o, sio_oe, host_oe, ioc_oe;
    logic           test_mode_o;
    logic [3:0]     host_clock_out_o;
    logic [5:0]     bus_o, bus_oe, bus_pad;
    logic [1:0]     spread_mode_o;
    logic [16:0]    host_khz, bus_khz, ref_khz;
    cksc_freq_sel_t freq_sel_o;
    initial forever #4 core_clk_i = ~core_clk_i;
    initial begin
        #3;
        forever #7.5 bus_clk = ~bus_clk;
    end
    initial forever #35 xtal = ~xtal;
    // wired-and data line; shared pads show straps while undriven, except bus pad 5, which shows the bus stop
    assign sda_w = ~(m_pull | sda_oe);
    assign bus_pad = (bus_oe & bus_o) | (~bus_oe & {stop_bus_n, 3'h7, strap[3], strap[2]});
    cksc_top cksc_top_i (.core_clk_i, .arst_n_i, .bus_clk_src_i(bus_clk), .host_clk_src_i(bus_clk),
        .ref_clk_src_i(xtal), .usb_clk_src_i(xtal), .sio_clk_src_i(xtal), .serial_clock_line_i(scl),
        .serial_data_line_i(sda_w), .serial_data_line_o(), .serial_data_line_oe_o(sda_oe), .host_clock_out_o,
        .host_clock_out_oe_o(host_oe), .mem_clk_o(), .mem_clk_oe_o(), .bus_clock_out_i(bus_pad),
        .bus_clock_out_o(bus_o), .bus_clock_out_oe_o(bus_oe), .free_running_bus_clock_i(fr_oe ? fr_o : strap[1]),
        .free_running_bus_clock_o(fr_o), .free_running_bus_clock_oe_o(fr_oe), .ref1_i, .ref_clk_o(),
        .ref_clk_oe_o(), .interrupt_controller_clock_o(), .interrupt_controller_clock_oe_o(ioc_oe),
        .usb48_i(usb_oe ? usb_o : strap[0]), .usb48_o(usb_o), .usb48_oe_o(usb_oe),
        .sio24_i(sio_oe ? sio_o : strap[4]), .sio24_o(sio_o), .sio24_oe_o(sio_oe), .freq_sel_o,
        .spread_mode_o, .host_freq_khz_o(host_khz), .bus_freq_khz_o(bus_khz), .ref_freq_khz_o(ref_khz),
        .test_mode_o);
    cksc_i2c_master cksc_i2c_master_i (.clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(m_pull));
    // ****************************************
    // compare, watch, verdict
    // ****************************************
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // or of clock outputs over n core cycles: usb, free-running, bus 0, host
    task automatic watch(input int n);
        seen = '0;
        repeat (n) begin
            @(negedge core_clk_i);
            seen |= {usb_o, fr_o, bus_o[0], host_clock_out_o};
        end
        @(posedge core_clk_i); // callers drive pins on a rising edge
    endtask : watch
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    initial begin
        fork
            begin
                #200us;
                bad_count++;
                end_sim();
            end
        join_none
        repeat (3) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (10) @(posedge core_clk_i); // oscillator settle, scaled down
        chk(17'(freq_sel_o), 17'h2);
        chk(host_khz, 17'h14f28);
        chk(bus_khz, 17'h0a730);
        chk(ref_khz, 17'h037ee);
        chk({spread_mode_o, test_mode_o, bus_oe, sio_oe, usb_oe, host_oe, ioc_oe}, 17'h1ff);
        cksc_i2c_master_i.xfer('{8'hd2, 8'h00, 8'h01, 8'h58}, acks);
        chk(17'(acks), 17'h4);
        chk(17'(freq_sel_o), 17'h5);
        chk(host_khz, 17'h124f8);
        chk(bus_khz, 17'h07d00);
        cksc_i2c_master_i.xfer('{8'hd4, 8'h00, 8'h01, 8'hf0}, acks);
        chk(17'(acks) + 17'(freq_sel_o), 17'h5);
        for (int m = 1; m < 4; m++) begin
            cksc_i2c_master_i.xfer('{8'hd2, 8'h00, 8'h01, 8'h58 | 8'(m)}, acks);
            chk({spread_mode_o, host_oe, bus_oe, ioc_oe}, (m == 3) ? 17'h300 : {7'h0, 2'(m), 8'hbf});
        end
        cksc_i2c_master_i.xfer('{8'hd2, 8'h00, 8'h03, 8'h58, 8'h4e, 8'h7f}, acks);
        chk(17'(acks), 17'h6);
        watch(100);
        chk({test_mode_o, seen}, 17'hbe);
        ref1_i <= 1'b0;
        stop_bus_n <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        watch(100);
        chk(17'(seen), 17'h20);
        ref1_i <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        watch(100);
        chk(17'(seen), 17'h2e);
        // second power-up: shared pins as clocks, stops unavailable
        strap <= 5'h1f;
        arst_n_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        chk(17'(freq_sel_o), 17'hf);
        chk(host_khz, 17'h104f0);
        chk(bus_khz, 17'h08278);
        chk({test_mode_o, bus_oe, sio_oe}, 17'h7f);
        ref1_i <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        watch(100);
        chk(17'(seen), 17'h7f);
        end_sim();
    end
endmodule : cksc_top_tb
